// >>> include/afe_sup_pkg.sv
/*
 * Constants, register offsets and field positions of the metering
 * front-end supervision block.
 * Assumes a single 250 MHz core clock and a word-level transaction port
 * that is already decoded from the serial slave link.
 */
// Overview of operation
// - Write lock refuses writes except lock word
// - Interrupt after set number of accumulated frames
// - Two-bit supply code: 00, 01, 11
// - Reset only from pin or reset register
// - Reset halts work, clears RAM, starts loader
// - Loader seeds static locations from OTP image
// - Loader refreshes one register each second
// - Reset sets event flag, interrupt low until cleared
// - Select bit zero: core drives gain trims
// - Trim = 16385 + lin*T/2^14 + quad*T^2/2^23
// - Select bit one: host writes gain trims
// - Factory coefficients loaded from OTP each reset
// - Fused reference trim code readable by host
// - Status byte reports previous transaction outcome
package afe_sup_pkg;
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam int          RAM_DEPTH    = 1024;
    localparam int          OTP_W        = 42;
    localparam int          TEMP_W       = 16;

    localparam logic [11:0] OFF_LIN      = 12'h01B;
    localparam logic [11:0] OFF_QUAD     = 12'h01C;
    localparam logic [11:0] OFF_CFG      = 12'h020;
    localparam logic [11:0] OFF_GAIN_V   = 12'h040;
    localparam logic [11:0] OFF_GAIN_IA  = 12'h041;
    localparam logic [11:0] OFF_GAIN_IB  = 12'h042;
    localparam logic [11:0] OFF_TEMP     = 12'h043;
    localparam logic [11:0] OFF_TRIM     = 12'h044;
    localparam logic [11:0] OFF_STAT     = 12'h045;
    localparam logic [11:0] OFF_LOCK     = 12'h046;
    localparam logic [11:0] OFF_SOFT_RST = 12'h322;

    localparam logic [31:0] CFG_RESET    = 32'h0030_3301;
    localparam int          CFG_HTC_BIT  = 24;
    localparam int          LOCK_BIT     = 0;
    localparam int          STAT_RST_BIT = 0;
    localparam int          STAT_ACC_BIT = 1;
    localparam int          STAT_SUP_LSB = 2;
    localparam logic [1:0]  STAT_FLAGS   = 2'h3;

    localparam logic [1:0]  SUP_GOOD     = 2'h0;
    localparam logic [1:0]  SUP_LOW      = 2'h1;
    localparam logic [1:0]  SUP_FAIL     = 2'h3;

    localparam logic [31:0] GAIN_BASE    = 32'h0000_4001;
    localparam int          LIN_SHIFT    = 14;
    localparam int          QUAD_SHIFT   = 23;

    localparam int          SB_REFUSED   = 0;
    localparam int          SB_BUSY      = 1;
    localparam int          SB_UNMAPPED  = 2;
    localparam int          SB_WRITE     = 3;

    localparam int          ACC_FRAMES   = 2520;
    localparam int          CLK_NS       = 4;
    localparam int          REFRESH_S    = 1;
    localparam longint     REFRESH_CYC  = longint'(REFRESH_S) * 64'd1000000000 / CLK_NS;

    typedef enum logic [1:0] {ST_CLEAR, ST_LOAD, ST_RUN} state_t;
endpackage : afe_sup_pkg

// >>> rtl/afe_word_ram.sv
/*
 * Single-port word memory with registered read data.
 * Assumes one access per clock; no reset, contents are cleared by the
 * owner walking every address.
 */
`timescale 1ns/1ns
module afe_word_ram #(
    parameter int W     = 32,
    parameter int DEPTH = 1024
) (
    input  wire logic                     clk_i,   // Core clock
    input  wire logic                     we_i,    // Write strobe
    input  wire logic [$clog2(DEPTH)-1:0] addr_i,  // Word address
    input  wire logic [W-1:0]             wdata_i, // Write data
    output logic      [W-1:0]             rdata_o  // Read data, one cycle late
);
    logic [W-1:0] mem [DEPTH];

    initial begin
        assert (DEPTH >= 2 && W >= 1) else $error("afe_word_ram: bad size");
    end

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : afe_word_ram

// >>> rtl/afe_supervisor.sv
/*
 * Supervision block: write lock, accumulation interrupt, supply code,
 * reset sequence with RAM clear and OTP image loader, periodic refresh,
 * and temperature compensation of the three gain trims.
 * Assumes transactions arrive decoded as one-cycle strobes and that
 * OTP_DATA_I follows OTP_ADDR_O within the same cycle.
 */
`timescale 1ns/1ns
module afe_supervisor #(
    parameter int LOAD_ENTRIES   = 16,
    parameter int OTP_AW         = 6,
    parameter int ACC_FRAMES     = afe_sup_pkg::ACC_FRAMES,
    parameter int REFRESH_CYCLES = int'(afe_sup_pkg::REFRESH_CYC)
) (
    input  wire logic              MCLK_I,       // Core clock
    input  wire logic              RESETN_I,     // Reset pin, sync, low
    input  wire logic              XFER_I,       // Transaction strobe
    input  wire logic              XFER_WR_I,    // 1 write, 0 read
    input  wire logic [11:0]       XFER_ADDR_I,  // Word address
    input  wire logic [31:0]       XFER_WDATA_I, // Write data
    output logic                   XFER_DONE_O,  // Answer pulse
    output logic      [31:0]       XFER_RDATA_O, // Read data
    output logic      [7:0]        XFER_STAT_O,  // Previous outcome
    input  wire logic              FRAME_I,      // Multiplexer frame pulse
    input  wire logic              SUPPLY_LOW_I, // Supply below first limit
    input  wire logic              SUPPLY_FAIL_I,// Supply below second limit
    input  wire logic [15:0]       DIE_TEMP_I,   // Die temperature, signed
    input  wire logic [7:0]        REF_TRIM_I,   // Fused reference trim
    output logic      [OTP_AW-1:0] OTP_ADDR_O,   // Image entry index
    input  wire logic [41:0]       OTP_DATA_I,   // {addr[9:0], data}
    output logic                   HOST_IRQ_N_O, // Host interrupt, low
    output logic      [1:0]        SUPPLY_STATE_O,// Supply state code
    output logic                   LOADING_O     // Clear or load running
);
    localparam int RAW = $clog2(afe_sup_pkg::RAM_DEPTH);
    localparam int FCW = $clog2(ACC_FRAMES + 1);
    localparam int RCW = $clog2(REFRESH_CYCLES + 1);

    initial begin
        assert (LOAD_ENTRIES >= 1 && LOAD_ENTRIES <= 2 ** OTP_AW && ACC_FRAMES >= 1
                && REFRESH_CYCLES >= 4) else $error("afe_supervisor: bad parameters");
    end

    afe_sup_pkg::state_t state_r;
    logic              soft_rst_r;
    logic [RAW-1:0]    clr_idx_r;
    logic [FCW-1:0]    frame_cnt_r;
    logic [RCW-1:0]    tick_r;
    logic              refresh_pend_r;
    logic [31:0]       lin_r, quad_r, cfg_r, gain_v_r, gain_ia_r, gain_ib_r, lock_r;
    logic [15:0]       temp_r;
    logic [1:0]        flags_r;
    logic              pend_r, rd_ok_r, rd_flop_r;
    logic [31:0]       rd_hold_r;
    logic [6:0]        cur_stat_r, prev_stat_r;
    logic [31:0]       ram_rdata;

    wire rst       = !RESETN_I || soft_rst_r;
    wire run       = state_r == afe_sup_pkg::ST_RUN;
    wire take      = XFER_I && run;
    wire [11:0] a  = XFER_ADDR_I;
    wire locked    = lock_r[afe_sup_pkg::LOCK_BIT];
    wire wr_ok     = take && XFER_WR_I && (!locked || a == afe_sup_pkg::OFF_LOCK);
    wire htc       = cfg_r[afe_sup_pkg::CFG_HTC_BIT];
    wire is_flop   = a == afe_sup_pkg::OFF_LIN || a == afe_sup_pkg::OFF_QUAD
                     || a == afe_sup_pkg::OFF_CFG || (a >= afe_sup_pkg::OFF_GAIN_V
                     && a <= afe_sup_pkg::OFF_LOCK);
    wire in_ram    = a < 12'(afe_sup_pkg::RAM_DEPTH);
    wire mapped    = is_flop || in_ram || a == afe_sup_pkg::OFF_SOFT_RST;
    wire soft_req  = wr_ok && a == afe_sup_pkg::OFF_SOFT_RST;
    wire host_ram_we = wr_ok && in_ram && !is_flop;
    wire acc_set   = run && FRAME_I && frame_cnt_r == FCW'(ACC_FRAMES - 1);
    wire tick_hit  = run && tick_r == RCW'(REFRESH_CYCLES - 1);
    wire refresh_go = run && refresh_pend_r && !take;
    wire last_entry = OTP_ADDR_O == OTP_AW'(LOAD_ENTRIES - 1);
    wire [1:0] sup_code = SUPPLY_FAIL_I ? afe_sup_pkg::SUP_FAIL :
                          SUPPLY_LOW_I  ? afe_sup_pkg::SUP_LOW  : afe_sup_pkg::SUP_GOOD;
    wire [31:0] stat_word = {28'h0000000, SUPPLY_STATE_O, flags_r};
    wire [1:0]  clr_mask  = wr_ok && a == afe_sup_pkg::OFF_STAT ? XFER_WDATA_I[1:0] : 2'h0;
    wire [1:0]  set_mask  = {acc_set, 1'b0};

    // RAM port owner: clear walk, then loader, then host with refresh behind it
    wire            ram_we    = !run || host_ram_we || refresh_go;
    wire [RAW-1:0]  ram_addr  = state_r == afe_sup_pkg::ST_CLEAR ? clr_idx_r :
                                (!run || refresh_go) ? OTP_DATA_I[41:32] : a[RAW-1:0];
    wire [31:0]     ram_wdata = state_r == afe_sup_pkg::ST_CLEAR ? 32'h0000_0000 :
                                (!run || refresh_go) ? OTP_DATA_I[31:0] : XFER_WDATA_I;

    wire [31:0] flop_rdata =
        a == afe_sup_pkg::OFF_LIN     ? lin_r     :
        a == afe_sup_pkg::OFF_QUAD    ? quad_r    :
        a == afe_sup_pkg::OFF_CFG     ? cfg_r     :
        a == afe_sup_pkg::OFF_GAIN_V  ? gain_v_r  :
        a == afe_sup_pkg::OFF_GAIN_IA ? gain_ia_r :
        a == afe_sup_pkg::OFF_GAIN_IB ? gain_ib_r :
        a == afe_sup_pkg::OFF_TEMP    ? {{16{temp_r[15]}}, temp_r} :
        a == afe_sup_pkg::OFF_TRIM    ? {24'h000000, REF_TRIM_I} :
        a == afe_sup_pkg::OFF_STAT    ? stat_word : lock_r;

    function automatic logic [31:0] comp_gain(input logic signed [31:0] lin,
                                              input logic signed [31:0] quad,
                                              input logic signed [15:0] t);
        logic signed [47:0] lt;
        logic signed [31:0] tt;
        logic signed [63:0] qt;
        lt = lin * t;
        tt = t * t;
        qt = quad * tt;
        comp_gain = afe_sup_pkg::GAIN_BASE + 32'(lt >>> afe_sup_pkg::LIN_SHIFT)
                    + 32'(qt >>> afe_sup_pkg::QUAD_SHIFT);
    endfunction : comp_gain

    wire [31:0] gain_calc = comp_gain(lin_r, quad_r, temp_r);

    afe_word_ram #(.W(32), .DEPTH(afe_sup_pkg::RAM_DEPTH)) u_ram (
        .clk_i   (MCLK_I),
        .we_i    (ram_we),
        .addr_i  (ram_addr),
        .wdata_i (ram_wdata),
        .rdata_o (ram_rdata)
    );

    // Soft reset lasts one cycle and is held off while the pin is low
    always_ff @(posedge MCLK_I) begin
        soft_rst_r <= RESETN_I && soft_req;
    end

    // Sequencer: clear RAM, load image, then run with periodic refresh
    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            state_r        <= afe_sup_pkg::ST_CLEAR;
            clr_idx_r      <= '0;
            OTP_ADDR_O     <= '0;
            tick_r         <= '0;
            refresh_pend_r <= 1'b0;
        end else begin
            case (state_r)
                afe_sup_pkg::ST_CLEAR: begin
                    clr_idx_r <= clr_idx_r + 1'b1;
                    if (&clr_idx_r) begin
                        state_r <= afe_sup_pkg::ST_LOAD;
                    end
                end
                afe_sup_pkg::ST_LOAD: begin
                    // Image also carries the factory coefficient words
                    OTP_ADDR_O <= last_entry ? '0 : OTP_ADDR_O + 1'b1;
                    if (last_entry) begin
                        state_r <= afe_sup_pkg::ST_RUN;
                    end
                end
                default: begin
                    tick_r <= tick_hit ? '0 : tick_r + 1'b1;
                    if (refresh_go) begin
                        OTP_ADDR_O <= last_entry ? '0 : OTP_ADDR_O + 1'b1;
                    end
                    refresh_pend_r <= tick_hit || (refresh_pend_r && !refresh_go);
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            lin_r     <= '0;
            quad_r    <= '0;
            cfg_r     <= afe_sup_pkg::CFG_RESET;
            lock_r    <= '0;
            gain_v_r  <= afe_sup_pkg::GAIN_BASE;
            gain_ia_r <= afe_sup_pkg::GAIN_BASE;
            gain_ib_r <= afe_sup_pkg::GAIN_BASE;
        end else begin
            if (wr_ok && a == afe_sup_pkg::OFF_LIN)  lin_r  <= XFER_WDATA_I;
            if (wr_ok && a == afe_sup_pkg::OFF_QUAD) quad_r <= XFER_WDATA_I;
            if (wr_ok && a == afe_sup_pkg::OFF_CFG)  cfg_r  <= XFER_WDATA_I;
            if (wr_ok && a == afe_sup_pkg::OFF_LOCK) lock_r <= XFER_WDATA_I;
            if (!htc) begin
                gain_v_r  <= gain_calc;
                gain_ia_r <= gain_calc;
                gain_ib_r <= gain_calc;
            end else begin
                if (wr_ok && a == afe_sup_pkg::OFF_GAIN_V)  gain_v_r  <= XFER_WDATA_I;
                if (wr_ok && a == afe_sup_pkg::OFF_GAIN_IA) gain_ia_r <= XFER_WDATA_I;
                if (wr_ok && a == afe_sup_pkg::OFF_GAIN_IB) gain_ib_r <= XFER_WDATA_I;
            end
        end
    end

    // Event flags: write one to clear, a new event in the same cycle wins
    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            flags_r        <= 2'h1;
            frame_cnt_r    <= '0;
            HOST_IRQ_N_O   <= 1'b0;
            SUPPLY_STATE_O <= afe_sup_pkg::SUP_GOOD;
            temp_r         <= '0;
            LOADING_O      <= 1'b1;
        end else begin
            flags_r        <= (flags_r & ~clr_mask) | set_mask;
            if (run && FRAME_I) begin
                frame_cnt_r <= acc_set ? '0 : frame_cnt_r + 1'b1;
            end
            HOST_IRQ_N_O   <= !(|(flags_r & ~clr_mask)) && !(|set_mask);
            SUPPLY_STATE_O <= sup_code;
            temp_r         <= DIE_TEMP_I;
            LOADING_O      <= !(state_r == afe_sup_pkg::ST_LOAD && last_entry) && !run;
        end
    end

    // Answer two cycles after the strobe; status shows the one before
    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            pend_r       <= 1'b0;
            rd_ok_r      <= 1'b0;
            rd_flop_r    <= 1'b0;
            rd_hold_r    <= '0;
            cur_stat_r   <= '0;
            prev_stat_r  <= '0;
            XFER_DONE_O  <= 1'b0;
            XFER_RDATA_O <= '0;
            XFER_STAT_O  <= '0;
        end else begin
            pend_r      <= XFER_I;
            rd_ok_r     <= take && !XFER_WR_I && mapped;
            rd_flop_r   <= is_flop;
            rd_hold_r   <= flop_rdata;
            if (XFER_I) begin
                cur_stat_r <= {3'h0, XFER_WR_I, !mapped, !run,
                               run && XFER_WR_I && !wr_ok};
            end
            XFER_DONE_O <= pend_r;
            if (pend_r) begin
                XFER_RDATA_O <= !rd_ok_r ? 32'h0000_0000 : rd_flop_r ? rd_hold_r : ram_rdata;
                XFER_STAT_O  <= {~^prev_stat_r, prev_stat_r};
                prev_stat_r  <= cur_stat_r;
            end
        end
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (rst);

    a_lock_blocks_write: assert property (locked && take && XFER_WR_I
        && a == afe_sup_pkg::OFF_LIN |=> lin_r == $past(lin_r))
        else $error("locked write changed a register");
    a_acc_raises_irq: assert property (acc_set |=> flags_r[1] ##1 !HOST_IRQ_N_O)
        else $error("accumulation did not raise interrupt");
    a_supply_code_map: assert property (SUPPLY_FAIL_I |=> SUPPLY_STATE_O == 2'h3)
        else $error("supply code wrong");
    a_soft_reset_seq: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        soft_req |=> soft_rst_r ##1 state_r == afe_sup_pkg::ST_CLEAR)
        else $error("soft reset did not restart");
    a_clear_to_load: assert property (state_r == afe_sup_pkg::ST_CLEAR
        && &clr_idx_r |=> state_r == afe_sup_pkg::ST_LOAD)
        else $error("clear did not hand over to loader");
    a_load_writes_ram: assert property (state_r == afe_sup_pkg::ST_LOAD
        |-> ram_we && ram_addr == OTP_DATA_I[41:32])
        else $error("loader did not write image entry");
    a_refresh_one_step: assert property (refresh_go |=> !refresh_pend_r
        && OTP_ADDR_O != $past(OTP_ADDR_O))
        else $error("refresh step wrong");
    a_reset_flag_set: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        soft_rst_r |=> flags_r[0] && !HOST_IRQ_N_O)
        else $error("reset event not flagged");
    a_internal_gain: assert property (!htc |=> gain_v_r == $past(gain_calc)
        && gain_ib_r == $past(gain_calc))
        else $error("internal compensation not applied");
    a_host_gain_hold: assert property (htc && !(wr_ok && a == afe_sup_pkg::OFF_GAIN_V)
        && $past(htc) |=> $stable(gain_v_r))
        else $error("gain trim moved in host mode");
    a_irq_release: assert property (flags_r == 2'h0 && !acc_set |=> HOST_IRQ_N_O)
        else $error("interrupt not released");

    c_soft_reset: cover property (soft_req);
    c_acc_irq: cover property (acc_set ##2 !HOST_IRQ_N_O);
    c_locked_refused: cover property (locked && take && XFER_WR_I && !wr_ok);
    c_refresh: cover property (refresh_go);
endmodule : afe_supervisor

// >>> dv/otp_image_model.sv
/*
 * Behavioural one-time-programmable image for the supervision block.
 * Assumes an asynchronous read: data follows the entry index at once.
 */
`timescale 1ns/1ns
module otp_image_model #(
    parameter int          OTP_AW    = 6,
    parameter int          ENTRIES   = 16,
    parameter logic [31:0] FACT_LIN  = 32'h0000_0100,
    parameter logic [31:0] FACT_QUAD = 32'h0000_0200
) (
    input  wire logic [OTP_AW-1:0] addr_i, // Image entry index
    output logic      [41:0]       data_o  // {ram word, data}
);
    logic [9:0] word_idx;

    assign word_idx = 10'h100 + 10'(addr_i);

    always_comb begin
        if (addr_i == '0) begin
            data_o = {10'h01D, FACT_LIN};
        end else if (addr_i == OTP_AW'(1)) begin
            data_o = {10'h01E, FACT_QUAD};
        end else if (int'(addr_i) < ENTRIES) begin
            data_o = {word_idx, 32'h5A00_0000 | 32'(addr_i)};
        end else begin
            // Unused entries toggle so a stray read cannot look plausible
            data_o = {10'h2AA, ~32'(addr_i)};
        end
    end
endmodule : otp_image_model

// >>> dv/testbench.sv
/*
 * Self-checking bench: register traffic, supply code, accumulation
 * interrupt, temperature compensation, write lock, refresh and resets.
 * Assumes the design's default one-cycle strobe port and a short
 * frame count and refresh period chosen here.
 */
`timescale 1ns/1ns
module testbench;
    localparam int          NE     = 16;
    localparam int          AW     = 6;
    localparam int          ACC    = 5;
    localparam logic [31:0] F_LIN  = 32'h0000_0100;
    localparam logic [31:0] F_QUAD = 32'h0000_0200;

    logic              mclk = 1'b0;
    logic              resetn = 1'b0;
    logic              xfer = 1'b0;
    logic              xfer_wr = 1'b0;
    logic [11:0]       xaddr = 12'h000;
    logic [31:0]       xwdata = 32'h0;
    logic              frame = 1'b0;
    logic              sup_low = 1'b0;
    logic              sup_fail = 1'b0;
    logic [15:0]       temp = 16'h0000;
    logic [7:0]        ref_trim = 8'hC3;
    logic              done;
    logic [31:0]       rdata;
    logic [7:0]        stat;
    logic [AW-1:0]     otp_addr;
    logic [41:0]       otp_data;
    logic              irq_n;
    logic [1:0]        sup_state;
    logic              loading;
    logic [31:0]       rd;
    logic [7:0]        st;
    logic [1:0]        sexp;
    logic signed [15:0] tv;
    int                error_cnt = 0;
    int                n_compared = 0;

    always #2 mclk = ~mclk;

    afe_supervisor #(.LOAD_ENTRIES(NE), .OTP_AW(AW), .ACC_FRAMES(ACC),
                     .REFRESH_CYCLES(64)) u_dut (
        .MCLK_I(mclk), .RESETN_I(resetn), .XFER_I(xfer), .XFER_WR_I(xfer_wr),
        .XFER_ADDR_I(xaddr), .XFER_WDATA_I(xwdata), .XFER_DONE_O(done),
        .XFER_RDATA_O(rdata), .XFER_STAT_O(stat), .FRAME_I(frame),
        .SUPPLY_LOW_I(sup_low), .SUPPLY_FAIL_I(sup_fail), .DIE_TEMP_I(temp),
        .REF_TRIM_I(ref_trim), .OTP_ADDR_O(otp_addr), .OTP_DATA_I(otp_data),
        .HOST_IRQ_N_O(irq_n), .SUPPLY_STATE_O(sup_state), .LOADING_O(loading));

    otp_image_model #(.OTP_AW(AW), .ENTRIES(NE), .FACT_LIN(F_LIN),
                      .FACT_QUAD(F_QUAD)) u_otp (.addr_i(otp_addr), .data_o(otp_data));

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Strobe for one cycle, then look for the answer on falling edges
    task automatic xfer_go(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(negedge mclk);
        xfer = 1'b1;
        xfer_wr = w;
        xaddr = a;
        xwdata = d;
        @(negedge mclk);
        xfer = 1'b0;
        while (done !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        rd = rdata;
        st = stat;
        // Soft reset swallows its own answer
        if (n == 4 && a != afe_sup_pkg::OFF_SOFT_RST) check(32'(done), 32'h1);
    endtask : xfer_go

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer_go(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        xfer_go(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    task automatic wait_run;
        int n;
        n = 0;
        while (loading !== 1'b0 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        check(32'(loading), 32'h0);
    endtask : wait_run

    task automatic pulse_frame;
        @(negedge mclk) frame = 1'b1;
        @(negedge mclk) frame = 1'b0;
        repeat (2) @(negedge mclk);
    endtask : pulse_frame

    function automatic logic [31:0] gain_exp(input logic signed [31:0] l,
                                             input logic signed [31:0] q,
                                             input logic signed [15:0] t);
        longint p1;
        longint p2;
        p1 = longint'(l) * longint'(t);
        p2 = longint'(q) * longint'(t) * longint'(t);
        return 32'h0000_4001 + 32'(p1 >>> 14) + 32'(p2 >>> 23);
    endfunction : gain_exp

    initial begin
        repeat (10) @(negedge mclk);
        resetn = 1'b1;
        wait_run();
        check(32'(irq_n), 32'h0);
        rd_chk(afe_sup_pkg::OFF_STAT, 32'h1);
        rd_chk(12'h01D, F_LIN);
        rd_chk(12'h01E, F_QUAD);
        rd_chk(12'h105, 32'h5A00_0005);
        rd_chk(12'h500, 32'h0);
        rd_chk(afe_sup_pkg::OFF_TRIM, {24'h0, ref_trim});
        check(32'(st), 32'h04);
        rd_chk(afe_sup_pkg::OFF_CFG, afe_sup_pkg::CFG_RESET);
        wr(afe_sup_pkg::OFF_STAT, 32'h1);
        check(32'(irq_n), 32'h1);
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk) {sup_fail, sup_low} = 2'(i);
            repeat (2) @(negedge mclk);
            sexp = sup_fail ? afe_sup_pkg::SUP_FAIL
                 : (sup_low ? afe_sup_pkg::SUP_LOW : afe_sup_pkg::SUP_GOOD);
            check(32'(sup_state), 32'(sexp));
            rd_chk(afe_sup_pkg::OFF_STAT, {28'h0, sexp, 2'b00});
        end
        {sup_fail, sup_low} = 2'b00;
        repeat (ACC - 1) pulse_frame();
        check(32'(irq_n), 32'h1);
        pulse_frame();
        check(32'(irq_n), 32'h0);
        rd_chk(afe_sup_pkg::OFF_STAT, 32'h2);
        wr(afe_sup_pkg::OFF_STAT, 32'h2);
        check(32'(irq_n), 32'h1);
        // Host restores working coefficients from the factory copies
        wr(afe_sup_pkg::OFF_LIN, F_LIN);
        wr(afe_sup_pkg::OFF_QUAD, F_QUAD);
        for (int j = 0; j < 2; j++) begin
            tv = (j == 0) ? 16'sd1000 : -16'sd2000;
            temp = tv;
            repeat (4) @(negedge mclk);
            rd_chk(afe_sup_pkg::OFF_TEMP, {{16{tv[15]}}, tv});
            wr(afe_sup_pkg::OFF_GAIN_V, 32'h1234);
            for (int k = 0; k < 3; k++)
                rd_chk(afe_sup_pkg::OFF_GAIN_V + 12'(k), gain_exp(F_LIN, F_QUAD, tv));
        end
        wr(afe_sup_pkg::OFF_CFG, afe_sup_pkg::CFG_RESET | (32'h1 << afe_sup_pkg::CFG_HTC_BIT));
        temp = 16'sd3000;
        for (int k = 0; k < 3; k++) wr(afe_sup_pkg::OFF_GAIN_V + 12'(k), 32'h4100 + k);
        repeat (4) @(negedge mclk);
        for (int k = 0; k < 3; k++)
            rd_chk(afe_sup_pkg::OFF_GAIN_V + 12'(k), 32'h4100 + k);
        wr(afe_sup_pkg::OFF_LOCK, 32'h1);
        wr(afe_sup_pkg::OFF_LIN, 32'h0000_0777);
        rd_chk(afe_sup_pkg::OFF_LIN, F_LIN);
        check(32'(st), 32'h89);
        wr(afe_sup_pkg::OFF_LOCK, 32'h0);
        wr(afe_sup_pkg::OFF_LIN, 32'h0000_0777);
        rd_chk(afe_sup_pkg::OFF_LIN, 32'h0000_0777);
        check(32'(st), 32'h08);
        wr(12'h103, 32'hDEAD_0000);
        wr(12'h200, 32'h0000_BEEF);
        repeat (NE * 64 + 80) @(negedge mclk);
        rd_chk(12'h103, 32'h5A00_0003);
        rd_chk(12'h200, 32'h0000_BEEF);
        wr(afe_sup_pkg::OFF_SOFT_RST, 32'h0);
        repeat (2) @(negedge mclk);
        check(32'(loading), 32'h1);
        // Request during the clear walk is answered but refused as busy
        rd_chk(afe_sup_pkg::OFF_CFG, 32'h0);
        check(32'(st), 32'h80);
        wait_run();
        check(32'(irq_n), 32'h0);
        rd_chk(12'h200, 32'h0);
        check(32'(st), 32'h02);
        rd_chk(afe_sup_pkg::OFF_LIN, 32'h0);
        rd_chk(12'h01D, F_LIN);
        rd_chk(afe_sup_pkg::OFF_STAT, 32'h1);
        give_verdict();
    end

    // Whole sequence needs well under 8000 cycles
    initial begin
        repeat (20000) @(negedge mclk);
        error_cnt++;
        give_verdict();
    end
endmodule : testbench
